// *** tflac_regs.svh ***
`ifndef TFLAC_REGS_SVH
`define TFLAC_REGS_SVH
// register offsets (byte addresses)
`define TFLAC_OFF_LATCHED_FILL_PEAK 12'h02C
`define TFLAC_OFF_CURRENT_FILL_LEVEL 12'h030
`define TFLAC_OFF_VACANCY_WATERMARK 12'h034
`define TFLAC_OFF_READ_POINTER_UPPER 12'h038
`define TFLAC_OFF_WRITE_POINTER_UPPER 12'h03C
`define TFLAC_OFF_MASTER_BUS_CONTROL 12'h110
`define TFLAC_OFF_BUFFER_BASE_LOW 12'h118
// field widths and positions
`define TFLAC_FILL_W 31
`define TFLAC_WM_W 30
`define TFLAC_PTR_HI_W 20
`define TFLAC_READ_CACHE_ATTR_LSB 16
`define TFLAC_WBURST_LSB 8
`define TFLAC_WRITE_CACHE_ATTR_LSB 2
`define TFLAC_SECURE_BIT 1
`define TFLAC_PRIV_BIT 0
`define TFLAC_BASE_RAZ_BITS 4
// reset values
`define TFLAC_RST_FILL 31'h00000000
`define TFLAC_RST_WM 30'h00000000
`define TFLAC_RST_PTR_HI 20'h00000
`define TFLAC_RST_CACHE 4'h0
`define TFLAC_RST_BURST 4'hF
`define TFLAC_RST_BASE 28'h0000000
// trace memory depth in 32-bit words
`define TFLAC_MEM_SIZE 31'h00001000
`endif

// *** tflac_pkg.sv ***
package tflac_pkg;
   // operating mode field encoding
   typedef enum logic [1:0] {
      TFLAC_MODE_CB = 2'h0,
      TFLAC_MODE_SOFTWARE_FIFO_ONE = 2'h1,
      TFLAC_MODE_RSVD = 2'h2,
      TFLAC_MODE_SOFTWARE_FIFO_TWO = 2'h3
   } tflac_mode_type;

   // master-bus attributes driven out
   typedef struct packed {
      logic [3:0] arcache;
      logic [3:0] awcache;
      logic [2:0] arprot;
      logic [2:0] awprot;
      logic [3:0] write_burst_max;
   } tflac_bus_attr_type;

   // programming port request
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } tflac_prog_req_type;
endpackage : tflac_pkg

// *** tflac_regbank.sv ***
`include "tflac_regs.svh"

module tflac_regbank (
   input wire logic clk,
   input wire logic rst_n,
   input wire tflac_pkg::tflac_prog_req_type prog_req,
   output logic [31:0] prog_rdata,
   output logic prog_ready,
   output logic prog_slverr,
   input wire tflac_pkg::tflac_mode_type mode_sel,
   input wire logic hw_fifo_mode,
   input wire logic disabled,
   input wire logic [30:0] occupancy,
   input wire logic ram_port_access,
   input wire logic write_ptr_wrap,
   output logic full,
   output logic status_full_flag,
   output tflac_pkg::tflac_bus_attr_type bus_attr,
   output logic [19:0] read_pointer_upper,
   output logic [19:0] write_pointer_upper,
   output logic [31:0] buffer_base_low
);
   import tflac_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [30:0] current_fill_reg;
   logic [30:0] latched_peak_reg;
   logic [29:0] watermark_reg;
   logic [19:0] rp_upper_reg;
   logic [19:0] wp_upper_reg;
   logic [3:0] read_cache_attr_reg;
   logic [3:0] write_cache_attr_reg;
   logic [3:0] wburst_reg;
   logic secure_reg;
   logic priv_reg;
   logic [27:0] base_low_reg;
   logic disabled_d_reg;
   logic wrap_full_reg;
   logic full_reg;

   // ----------------------------------------
   // access decode
   // ----------------------------------------
   logic acc;
   logic wr;
   logic rd;
   logic leave_disabled;
   logic cb_mode;
   logic fifo_mode;
   logic [31:0] full_limit;

   assign acc = prog_req.sel && prog_req.enable;
   assign wr = acc && prog_req.write;
   assign rd = acc && !prog_req.write;
   assign prog_ready = 1'b1;
   assign prog_slverr = 1'b0;
   assign leave_disabled = disabled_d_reg && !disabled;

   // reserved mode acts as fifo one, so only code 0 is circular
   assign cb_mode = !hw_fifo_mode && (mode_sel == TFLAC_MODE_CB);
   assign fifo_mode = !cb_mode;

   // cache encodings legal for the master bus
   function automatic logic cache_valid(input logic [3:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : cache_valid

   // ----------------------------------------
   // disabled-state edge tracking
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         disabled_d_reg <= 1'b1;
      end else begin
         disabled_d_reg <= disabled;
      end
   end

   // current level: tracks when enabled, ram port only when disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         current_fill_reg <= `TFLAC_RST_FILL;
      end else if (!disabled) begin
         current_fill_reg <= occupancy;
      end else if (ram_port_access) begin
         current_fill_reg <= occupancy;
      end
   end

   // peak level since last read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_peak_reg <= `TFLAC_RST_FILL;
      end else if (leave_disabled) begin
         latched_peak_reg <= occupancy;
      end else if (!disabled) begin
         if (rd && prog_req.addr == `TFLAC_OFF_LATCHED_FILL_PEAK) begin
            latched_peak_reg <= occupancy;
         end else if (occupancy > latched_peak_reg) begin
            latched_peak_reg <= occupancy;
         end
      end
      // disabled: hold value, reads leave it alone
   end

   // ----------------------------------------
   // writable configuration
   // ----------------------------------------
   // vacancy watermark, bits above the field are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watermark_reg <= `TFLAC_RST_WM;
      end else if (wr && prog_req.addr == `TFLAC_OFF_VACANCY_WATERMARK) begin
         watermark_reg <= prog_req.wdata[`TFLAC_WM_W-1:0];
      end
   end

   // upper pointer bits for reads and writes of trace memory
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rp_upper_reg <= `TFLAC_RST_PTR_HI;
         wp_upper_reg <= `TFLAC_RST_PTR_HI;
      end else if (wr) begin
         if (prog_req.addr == `TFLAC_OFF_READ_POINTER_UPPER) begin
            rp_upper_reg <= prog_req.wdata[`TFLAC_PTR_HI_W-1:0];
         end
         if (prog_req.addr == `TFLAC_OFF_WRITE_POINTER_UPPER) begin
            wp_upper_reg <= prog_req.wdata[`TFLAC_PTR_HI_W-1:0];
         end
      end
   end

   // master-bus control, invalid cache encodings stored as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_cache_attr_reg <= `TFLAC_RST_CACHE;
         write_cache_attr_reg <= `TFLAC_RST_CACHE;
         wburst_reg <= `TFLAC_RST_BURST;
         secure_reg <= 1'b0;
         priv_reg <= 1'b0;
      end else if (wr && prog_req.addr == `TFLAC_OFF_MASTER_BUS_CONTROL) begin
         read_cache_attr_reg <= cache_valid(prog_req.wdata[`TFLAC_READ_CACHE_ATTR_LSB +: 4]) ?
                       prog_req.wdata[`TFLAC_READ_CACHE_ATTR_LSB +: 4] : 4'h0;
         write_cache_attr_reg <= cache_valid(prog_req.wdata[`TFLAC_WRITE_CACHE_ATTR_LSB +: 4]) ?
                       prog_req.wdata[`TFLAC_WRITE_CACHE_ATTR_LSB +: 4] : 4'h0;
         wburst_reg <= prog_req.wdata[`TFLAC_WBURST_LSB +: 4];
         secure_reg <= prog_req.wdata[`TFLAC_SECURE_BIT];
         priv_reg <= prog_req.wdata[`TFLAC_PRIV_BIT];
      end
   end

   // buffer base, the always-zero low bits are not stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         base_low_reg <= `TFLAC_RST_BASE;
      end else if (wr && prog_req.addr == `TFLAC_OFF_BUFFER_BASE_LOW) begin
         base_low_reg <= prog_req.wdata[31:`TFLAC_BASE_RAZ_BITS];
      end
   end

   // ----------------------------------------
   // full indication
   // ----------------------------------------
   // circular mode: wrap is sticky until capture leaves and re-enters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrap_full_reg <= 1'b0;
      end else if (cb_mode && write_ptr_wrap) begin
         wrap_full_reg <= 1'b1;
      end else if (leave_disabled) begin
         wrap_full_reg <= 1'b0; // a wrap in the same cycle wins
      end
   end

   assign full_limit = {1'b0, `TFLAC_MEM_SIZE} - {2'b00, watermark_reg};

   // registered full, one clock after occupancy changes (fifo modes) or after a wrap (circular mode)
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full_reg <= 1'b0;
      end else if (fifo_mode) begin
         full_reg <= ({1'b0, occupancy} >= full_limit);
      end else begin
         full_reg <= wrap_full_reg || (cb_mode && write_ptr_wrap);
      end
   end

   assign full = full_reg;
   assign status_full_flag = full_reg;

   // ----------------------------------------
   // outputs to the master bus
   // ----------------------------------------
   always_comb begin
      bus_attr.arcache = read_cache_attr_reg;
      bus_attr.awcache = write_cache_attr_reg;
      bus_attr.arprot = {1'b0, secure_reg, priv_reg};
      bus_attr.awprot = {1'b0, secure_reg, priv_reg};
      bus_attr.write_burst_max = wburst_reg;
   end

   assign read_pointer_upper = rp_upper_reg;
   assign write_pointer_upper = wp_upper_reg;
   assign buffer_base_low = {base_low_reg, 4'h0};

   // ----------------------------------------
   // read data mux
   // ----------------------------------------
   // register contents back onto the programming port
   always_comb begin
      prog_rdata = 32'h00000000;
      case (prog_req.addr)
         `TFLAC_OFF_LATCHED_FILL_PEAK: prog_rdata = {1'b0, latched_peak_reg};
         `TFLAC_OFF_CURRENT_FILL_LEVEL: prog_rdata = {1'b0, current_fill_reg};
         `TFLAC_OFF_VACANCY_WATERMARK: prog_rdata = {2'b00, watermark_reg};
         `TFLAC_OFF_READ_POINTER_UPPER: prog_rdata = {12'h000, rp_upper_reg};
         `TFLAC_OFF_WRITE_POINTER_UPPER: prog_rdata = {12'h000, wp_upper_reg};
         `TFLAC_OFF_MASTER_BUS_CONTROL: prog_rdata = {12'h000, read_cache_attr_reg, 4'h0,
                                                    wburst_reg, 2'b00, write_cache_attr_reg,
                                                    secure_reg, priv_reg};
         `TFLAC_OFF_BUFFER_BASE_LOW: prog_rdata = {base_low_reg, 4'h0};
         default: prog_rdata = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_PROT2_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      !bus_attr.arprot[2] && !bus_attr.awprot[2])
      else $error("prot bit 2 driven high");

   AST_PEAK_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && !disabled && !leave_disabled &&
       prog_req.addr == `TFLAC_OFF_LATCHED_FILL_PEAK) |=> latched_peak_reg == $past(occupancy))
      else $error("peak not reloaded on read");

   AST_PEAK_MONOTONIC: assert property (@(posedge clk) disable iff (!rst_n)
      (!disabled && !leave_disabled && !rd) |=> latched_peak_reg >= $past(occupancy))
      else $error("peak below occupancy");

   AST_PEAK_HOLD_DIS: assert property (@(posedge clk) disable iff (!rst_n)
      (disabled && $past(disabled)) |=> $stable(latched_peak_reg))
      else $error("peak changed while disabled");

   AST_PEAK_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
      leave_disabled |=> latched_peak_reg == $past(occupancy))
      else $error("peak not loaded on exit");

   AST_CUR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (disabled && !ram_port_access) |=> $stable(current_fill_reg))
      else $error("current level changed while disabled");

   AST_FULL_WM: assert property (@(posedge clk) disable iff (!rst_n)
      fifo_mode |=> full == ($past(occupancy) >= (`TFLAC_MEM_SIZE - $past(watermark_reg))))
      else $error("full mismatch against watermark");

   AST_CB_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
      (cb_mode && write_ptr_wrap) |=> full)
      else $error("full missing after wrap");

   AST_RSVD_BIT31: assert property (@(posedge clk) disable iff (!rst_n)
      (prog_req.addr == `TFLAC_OFF_CURRENT_FILL_LEVEL) |-> !prog_rdata[31])
      else $error("fill bit 31 nonzero");

   AST_CACHE_VALID: assert property (@(posedge clk) disable iff (!rst_n)
      cache_valid(read_cache_attr_reg) && cache_valid(write_cache_attr_reg))
      else $error("invalid cache encoding stored");

   AST_CUR_TRACK: assert property (@(posedge clk) disable iff (!rst_n)
      !disabled |=> current_fill_reg == $past(occupancy))
      else $error("current level not tracking");

   AST_CUR_RAM: assert property (@(posedge clk) disable iff (!rst_n)
      (disabled && ram_port_access) |=> current_fill_reg == $past(occupancy))
      else $error("current level missed ram port access");

   AST_PEAK_RAZ: assert property (@(posedge clk) disable iff (!rst_n)
      (prog_req.addr == `TFLAC_OFF_LATCHED_FILL_PEAK) |-> !prog_rdata[31])
      else $error("peak bit 31 nonzero");

   AST_WM_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && prog_req.addr == `TFLAC_OFF_VACANCY_WATERMARK) |=>
      watermark_reg == $past(prog_req.wdata[`TFLAC_WM_W-1:0]))
      else $error("watermark not stored");

   AST_WM_RAZ: assert property (@(posedge clk) disable iff (!rst_n)
      (prog_req.addr == `TFLAC_OFF_VACANCY_WATERMARK) |-> prog_rdata[31:30] == 2'b00)
      else $error("watermark bits 31:30 nonzero");

   AST_PTR_RAZ: assert property (@(posedge clk) disable iff (!rst_n)
      (prog_req.addr == `TFLAC_OFF_READ_POINTER_UPPER ||
       prog_req.addr == `TFLAC_OFF_WRITE_POINTER_UPPER) |-> prog_rdata[31:20] == 12'h000)
      else $error("pointer upper bits 31:20 nonzero");

   AST_READ_CACHE_ATTR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && prog_req.addr == `TFLAC_OFF_MASTER_BUS_CONTROL &&
       !cache_valid(prog_req.wdata[`TFLAC_READ_CACHE_ATTR_LSB +: 4])) |=> bus_attr.arcache == 4'h0)
      else $error("invalid read cache code not zeroed");

   AST_WRITE_CACHE_ATTR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && prog_req.addr == `TFLAC_OFF_MASTER_BUS_CONTROL &&
       !cache_valid(prog_req.wdata[`TFLAC_WRITE_CACHE_ATTR_LSB +: 4])) |=> bus_attr.awcache == 4'h0)
      else $error("invalid write cache code not zeroed");

   AST_BURST_CAP: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && prog_req.addr == `TFLAC_OFF_MASTER_BUS_CONTROL) |=>
      bus_attr.write_burst_max == $past(prog_req.wdata[`TFLAC_WBURST_LSB +: 4]))
      else $error("write burst cap not driven");

   AST_PROT_SEL: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && prog_req.addr == `TFLAC_OFF_MASTER_BUS_CONTROL) |=>
      bus_attr.arprot[1:0] == $past(prog_req.wdata[1:0]) &&
      bus_attr.awprot[1:0] == $past(prog_req.wdata[1:0]))
      else $error("protection select bits not driven");

   AST_BASE_RAZ: assert property (@(posedge clk) disable iff (!rst_n)
      buffer_base_low[`TFLAC_BASE_RAZ_BITS-1:0] == 4'h0)
      else $error("buffer base low bits nonzero");

   AST_CB_NO_WM: assert property (@(posedge clk) disable iff (!rst_n)
      (cb_mode && !write_ptr_wrap && !wrap_full_reg) |=> !full)
      else $error("full raised in circular mode without wrap");
endmodule : tflac_regbank

// *** tflac_mem_model.sv ***
`include "tflac_regs.svh"

// trace memory side: occupancy and a write pointer that wraps at the memory depth
module tflac_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_en,
   input wire logic [30:0] set_level,
   input wire logic word_wr,
   output logic [30:0] occupancy,
   output logic write_ptr_wrap
);
   logic [30:0] wptr_reg;
   logic at_end;

   // last word of the buffer
   assign at_end = (wptr_reg == (`TFLAC_MEM_SIZE - 31'h00000001));

   // load or advance the level and the pointer, pulse on the wrap
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         occupancy <= 31'h00000000;
         wptr_reg <= 31'h00000000;
         write_ptr_wrap <= 1'b0;
      end else begin
         write_ptr_wrap <= word_wr && at_end;
         if (set_en) begin
            occupancy <= set_level;
            wptr_reg <= set_level;
         end else if (word_wr) begin
            occupancy <= occupancy + 31'h00000001;
            wptr_reg <= at_end ? 31'h00000000 : wptr_reg + 31'h00000001;
         end
      end
   end
endmodule : tflac_mem_model

// *** tflac_regbank_tb.sv ***
module tflac_regbank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import tflac_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   tflac_prog_req_type prog_req = '0;
   tflac_mode_type mode_sel = TFLAC_MODE_SOFTWARE_FIFO_ONE;
   tflac_bus_attr_type bus_attr;
   logic hw_fifo_mode = 1'b0, disabled = 1'b1, ram_port_access = 1'b0;
   logic set_en = 1'b0, word_wr = 1'b0, write_ptr_wrap, full, status_full_flag;
   logic prog_ready, prog_slverr;
   logic [30:0] set_lvl = 31'h00000000, occupancy;
   logic [31:0] prog_rdata, buffer_base_low, cw, c;
   logic [19:0] read_pointer_upper, write_pointer_upper;
   int num_errors = 0, num_checks = 0, cyc = 0;

   tflac_regbank tflac_regbank_inst (.clk(clk), .rst_n(rst_n), .prog_req(prog_req),
      .prog_rdata(prog_rdata), .prog_ready(prog_ready), .prog_slverr(prog_slverr),
      .mode_sel(mode_sel), .hw_fifo_mode(hw_fifo_mode), .disabled(disabled),
      .occupancy(occupancy), .ram_port_access(ram_port_access),
      .write_ptr_wrap(write_ptr_wrap), .full(full), .status_full_flag(status_full_flag),
      .bus_attr(bus_attr), .read_pointer_upper(read_pointer_upper),
      .write_pointer_upper(write_pointer_upper), .buffer_base_low(buffer_base_low));
   tflac_mem_model tflac_mem_model_inst (.clk(clk), .rst_n(rst_n), .set_en(set_en),
      .set_level(set_lvl), .word_wr(word_wr), .occupancy(occupancy),
      .write_ptr_wrap(write_ptr_wrap));

   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         wrap_up();
      end
   end

   //----------------------------------------
   // access and compare tasks
   //----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      #1 prog_req = '{1'b1, 1'b1, 1'b1, a, d};
      @(posedge clk);
      #1 prog_req = '0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
      @(posedge clk);
      #1 prog_req = '{1'b1, 1'b1, 1'b0, a, 32'h00000000};
      @(posedge clk);
      chk(name, exp, prog_rdata);
      #1 prog_req = '0;
   endtask : rd
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic lvl(input logic [30:0] v);
      set_en = 1'b1;
      set_lvl = v;
      step();
      set_en = 1'b0;
      step();
   endtask : lvl
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   //----------------------------------------
   // test sequence
   //----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(12'h110, 32'h00000F00, "ctrl_reset");
      chk("attr_reset", 32'h0000000F, {14'h0000, bus_attr});
      wr(12'h034, 32'hFFFFFFFF);
      rd(12'h034, 32'h3FFFFFFF, "wm_raz");
      wr(12'h038, 32'hFFFFFFFF);
      rd(12'h038, 32'h000FFFFF, "rptr_hi");
      wr(12'h03C, 32'hFFFFFFFF);
      rd(12'h03C, 32'h000FFFFF, "wptr_hi");
      wr(12'h118, 32'hFFFFFFFF);
      rd(12'h118, 32'hFFFFFFF0, "base_lo");
      chk("pins", 32'hFFFFFFF0, buffer_base_low);
      chk("ptr_pins", 32'h000000FF, {24'h0, read_pointer_upper[19:16], write_pointer_upper[3:0]});
      wr(12'h030, 32'hFFFFFFFF);
      rd(12'h030, 32'h00000000, "cur_wi");
      rd(12'h040, 32'h00000000, "unmapped");
      chk("resp", 32'h00000002, {30'h0, prog_ready, prog_slverr});
      $display("test regs done");
      // every cache code on both fields, with protection bits and burst cap
      for (int i = 0; i < 16; i++) begin
         c = (16'hCCCF >> i) & 1 ? i : 0;
         cw = 32'hFFF0F0C0 | (i << 16) | 32'h00000500 | (i << 2) | (i & 3);
         wr(12'h110, cw);
         rd(12'h110, (c << 16) | 32'h00000500 | (c << 2) | (i & 3), "ctrl");
         chk("attr", {c[3:0], c[3:0], 1'b0, i[1:0], 1'b0, i[1:0], 4'h5}, {14'h0, bus_attr});
      end
      $display("test cache done");
      lvl(31'h0000000A);
      disabled = 1'b0;
      lvl(31'h00000032);
      lvl(31'h00000014);
      rd(12'h02C, 32'h00000032, "peak");
      rd(12'h02C, 32'h00000014, "peak_reload");
      rd(12'h030, 32'h00000014, "cur");
      disabled = 1'b1;
      lvl(31'h0000001E);
      rd(12'h030, 32'h00000014, "cur_hold");
      ram_port_access = 1'b1;
      step();
      ram_port_access = 1'b0;
      rd(12'h030, 32'h0000001E, "cur_ram");
      rd(12'h02C, 32'h00000014, "peak_dis");
      rd(12'h02C, 32'h00000014, "peak_dis2");
      lvl(31'h0000000C);
      disabled = 1'b0;
      lvl(31'h00000005);
      rd(12'h02C, 32'h0000000C, "peak_exit");
      $display("test levels done");
      disabled = 1'b1;
      wr(12'h034, 32'h00000100);
      disabled = 1'b0;
      for (int k = 0; k < 4; k++) begin
         mode_sel = tflac_mode_type'(k[1:0] == 2'h3 ? 2'h0 : k[1:0] + 2'h1);
         hw_fifo_mode = (k == 3);
         lvl(31'h00000EFF);
         step();
         chk("full_below", 32'h0, {31'h0, full});
         lvl(31'h00000F00);
         chk("full", 32'h3, {30'h0, full, status_full_flag});
      end
      disabled = 1'b1;
      wr(12'h034, 32'h00000FFF);
      disabled = 1'b0;
      lvl(31'h00000000);
      step();
      chk("full_max_wm0", 32'h0, {31'h0, full});
      lvl(31'h00000001);
      chk("full_max_wm1", 32'h1, {31'h0, full});
      hw_fifo_mode = 1'b0;
      mode_sel = TFLAC_MODE_CB;
      lvl(31'h00000FFF);
      step();
      chk("cb_no_wm", 32'h0, {31'h0, full});
      word_wr = 1'b1;
      step();
      word_wr = 1'b0;
      step();
      step();
      chk("cb_wrap", 32'h1, {31'h0, full});
      disabled = 1'b1;
      step();
      disabled = 1'b0;
      step();
      step();
      chk("cb_clear", 32'h0, {31'h0, full});
      $display("test full done");
      wrap_up();
   end
endmodule : tflac_regbank_tb
